// file: rtl/serial_sram_dev.sv
// Memory end of the serial link with single and dual line modes
//
// Behaviour
// - Input bits captured on serial clock rise
// - Output changes only after serial clock fall
// - Dual lines reuse the input and output pins
// - Dual mode moves two bits, high first
// - Enter command makes later transactions dual
// - Exit command sent in current line format
// - Reset controller forces memory back to single line mode
// - Enter command code is 3B hex
// - Exit command code is FF hex
// - Select low throughout; raising it releases lines
// - Instruction, 16-bit address, data, high first
`timescale 1ns/1ps
`default_nettype none
`include "link_defs.svh"
module serial_sram_dev (
   // Link pins
   spi_link_if.device        link,
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Write side toward the storage
   output logic              wr_valid,
   output logic [15:0]       wr_addr,
   output logic [7:0]        wr_data,
   // Read side toward the storage
   output logic              rd_req,
   output logic [15:0]       rd_addr,
   input  wire logic [7:0]   rd_data,
   // Current line mode
   output logic              dual_line_mode
);
   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [2:0]             cs_s_q;     // Select, stage 2 for edges
   logic [2:0]             sck_s_q;    // Clock, stage 2 for edges
   logic [1:0]             l0_s_q;     // Line zero
   logic [1:0]             l1_s_q;     // Line one

   // Two stages before any logic; third only for edge finding
   always_ff @(posedge mclk) begin
      if (rst) begin
         cs_s_q  <= 3'h7;
         sck_s_q <= 3'h0;
         l0_s_q  <= 2'h3;
         l1_s_q  <= 2'h3;
      end else begin
         cs_s_q  <= {cs_s_q[1:0], link.cs_n};
         sck_s_q <= {sck_s_q[1:0], link.sck};
         l0_s_q  <= {l0_s_q[0], link.dual_line_zero};
         l1_s_q  <= {l1_s_q[0], link.dual_line_one};
      end
   end

   // ==========================================================
   // Decoded events
   // ==========================================================
   logic                   cs_n;       // Synchronised select
   logic                   cs_rise;    // End of a transaction
   logic                   sck_rise;   // Serial clock rise seen
   logic                   sck_fall;   // Serial clock fall seen
   logic [3:0]             step;       // Bits moved per clock
   logic [3:0]             bits_next;  // Bit count after this clock
   logic                   byte_done;  // Last bit of a byte arrives
   logic [7:0]             byte_in;    // Byte with this clock's bits

   assign cs_n     = cs_s_q[1];
   assign cs_rise  = cs_s_q[1] & ~cs_s_q[2];
   assign sck_rise = ~cs_n & sck_s_q[1] & ~sck_s_q[2];
   assign sck_fall = ~cs_n & ~sck_s_q[1] & sck_s_q[2];

   // ==========================================================
   // Mode and byte assembly
   // ==========================================================
   logic                   dual_q;     // Dual line mode active
   logic                   pend_en_q;  // Enter seen this transaction
   logic                   pend_ex_q;  // Exit seen this transaction
   logic [3:0]             bits_q;     // Bits of the current byte
   logic [7:0]             sh_in_q;    // Incoming shift register

   assign step      = dual_q ? 4'h2 : 4'h1;
   assign bits_next = bits_q + step;
   assign byte_done = sck_rise & (bits_next == `BYTE_BITS);
   // Line one carries the higher bit of each pair
   assign byte_in   = dual_q ? {sh_in_q[5:0], l1_s_q[1], l0_s_q[1]}
                             : {sh_in_q[6:0], l0_s_q[1]};

   // Shift in on each rise; a partial byte is dropped at deselect
   always_ff @(posedge mclk) begin
      if (rst || cs_n) begin
         bits_q  <= 4'h0;
         sh_in_q <= 8'h00;
      end else if (sck_rise) begin
         bits_q  <= byte_done ? 4'h0 : bits_next;
         sh_in_q <= byte_in;
      end
   end

   // Mode changes only at deselect, so the command's own
   // transaction keeps its format to the end
   always_ff @(posedge mclk) begin
      if (rst) begin
         dual_q <= 1'b0;
      end else if (cs_rise && pend_ex_q) begin
         dual_q <= 1'b0;
      end else if (cs_rise && pend_en_q) begin
         dual_q <= 1'b1;
      end
   end

   // ==========================================================
   // Transaction decoder
   // ==========================================================
   link_pkg::dev_state_t   state_q;    // Decoder state
   logic                   addr_hi_q;  // High address byte taken
   logic [15:0]            addr_q;     // Running byte address
   logic                   wr_valid_q; // Write strobe
   logic [7:0]             wr_data_q;  // Write byte
   logic [15:0]            wr_addr_q;  // Write address
   logic                   rd_req_q;   // Read fetch strobe
   logic                   load_q;     // Load next byte at next fall
   logic                   state_rd_q; // Current command reads
   logic                   is_enter;   // Command byte is enter
   logic                   is_exit;    // Command byte is exit
   logic                   is_read;    // Command byte is read
   logic                   is_write;   // Command byte is write

   assign is_enter = (byte_in == `ENTER_DUAL_CMD);
   assign is_exit  = (byte_in == `EXIT_DUAL_CMD);
   assign is_read  = (byte_in == `READ_CMD);
   assign is_write = (byte_in == `WRITE_CMD);

   // Walk instruction, address and data bytes
   always_ff @(posedge mclk) begin
      wr_valid_q <= 1'b0;
      rd_req_q   <= 1'b0;
      if (rst) begin
         state_q   <= link_pkg::st_cmd;
         addr_hi_q <= 1'b0;
         addr_q    <= 16'h0000;
         wr_data_q <= 8'h00;
         wr_addr_q <= 16'h0000;
         pend_en_q <= 1'b0;
         pend_ex_q <= 1'b0;
      end else if (cs_n) begin
         // Deselect ends any operation
         state_q   <= link_pkg::st_cmd;
         addr_hi_q <= 1'b0;
         pend_en_q <= 1'b0;
         pend_ex_q <= 1'b0;
      end else if (byte_done) begin
         unique case (state_q)
            link_pkg::st_cmd: begin
               // Unknown and mode commands ignore the rest
               pend_en_q <= is_enter;
               pend_ex_q <= is_exit;
               if (is_read || is_write) begin
                  state_q <= link_pkg::st_addr;
               end else begin
                  state_q <= link_pkg::st_skip;
               end
            end
            link_pkg::st_addr: begin
               // Address arrives high byte first
               addr_q    <= {addr_q[7:0], byte_in};
               addr_hi_q <= 1'b1;
               if (addr_hi_q) begin
                  if (state_rd_q) begin
                     state_q  <= link_pkg::st_rdata;
                     rd_req_q <= 1'b1;
                  end else begin
                     state_q  <= link_pkg::st_wdata;
                  end
               end
            end
            link_pkg::st_wdata: begin
               // Each byte goes out and the address moves on
               wr_valid_q <= 1'b1;
               wr_data_q  <= byte_in;
               wr_addr_q  <= addr_q;
               addr_q     <= addr_q + 16'h0001;
            end
            link_pkg::st_rdata: begin
               // Fetch the next byte well before the next fall
               addr_q   <= addr_q + 16'h0001;
               rd_req_q <= 1'b1;
            end
            link_pkg::st_skip: begin
               // Extra clocks after a mode command do nothing
               state_q <= link_pkg::st_skip;
            end
            default: begin
               state_q <= link_pkg::st_skip;
            end
         endcase
      end
   end

   // Remember whether the command was a read
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_rd_q <= 1'b0;
      end else if (byte_done && state_q == link_pkg::st_cmd) begin
         state_rd_q <= is_read;
      end
   end

   // ==========================================================
   // Read shifter and line drive
   // ==========================================================
   logic [7:0]             sh_out_q;   // Outgoing shift register
   logic                   drive_q;    // Driving the output lines
   logic [7:0]             sh_shift;   // Shifter after one fall

   assign sh_shift = dual_q ? {sh_out_q[5:0], 2'h0}
                            : {sh_out_q[6:0], 1'h0};

   // Load arms on each fetch so the first fall after it loads
   always_ff @(posedge mclk) begin
      if (rst || cs_n) begin
         load_q <= 1'b0;
      end else if (rd_req_q) begin
         load_q <= 1'b1;
      end else if (sck_fall) begin
         load_q <= 1'b0;
      end
   end

   // Output bits move only on a fall; the host samples on a rise
   always_ff @(posedge mclk) begin
      if (rst || cs_n) begin
         sh_out_q <= 8'h00;
         drive_q  <= 1'b0;
      end else if (sck_fall && state_q == link_pkg::st_rdata) begin
         sh_out_q <= load_q ? rd_data : sh_shift;
         drive_q  <= 1'b1;
      end
   end

   // In single mode only line one drives; dual uses both
   assign link.l1_dev_o  = sh_out_q[7];
   assign link.l1_dev_oe = drive_q & ~cs_n;
   assign link.l0_dev_o  = sh_out_q[6];
   assign link.l0_dev_oe = drive_q & ~cs_n & dual_q;

   // ==========================================================
   // User side outputs
   // ==========================================================
   assign wr_valid       = wr_valid_q;
   assign wr_addr        = wr_addr_q;
   assign wr_data        = wr_data_q;
   assign rd_req         = rd_req_q;
   assign rd_addr        = addr_q;
   assign dual_line_mode = dual_q;
endmodule
`default_nettype wire

// file: rtl/link_defs.svh
// Constants shared by both ends of the serial memory link
`ifndef LINK_DEFS_SVH
`define LINK_DEFS_SVH
// Instruction codes
`define ENTER_DUAL_CMD 8'h3B
`define EXIT_DUAL_CMD  8'hFF
`define READ_CMD       8'h03
`define WRITE_CMD      8'h02
// Bit counts of a transaction
`define BYTE_BITS      4'h8
`define RW_BITS        6'h20
`define CMD_BITS       6'h08
`define RX_BITS        6'h08
// Serial clock timing, in nanoseconds and in mclk cycles
`define MCLK_NS        4
`define SCK_HALF_NS    80
`define SCK_HALF_CYC   ((`SCK_HALF_NS + `MCLK_NS - 1) / `MCLK_NS)
`endif

// file: rtl/link_pkg.sv
// Types shared by both ends of the serial memory link
package link_pkg;
   // Memory end decoder states
   typedef enum logic [2:0] {
      st_cmd   = 3'h0,
      st_addr  = 3'h1,
      st_wdata = 3'h2,
      st_rdata = 3'h3,
      st_skip  = 3'h4
   } dev_state_t;
   // Controller sequencer states
   typedef enum logic [2:0] {
      h_idle  = 3'h0,
      h_setup = 3'h1,
      h_low   = 3'h2,
      h_high  = 3'h3,
      h_gap   = 3'h4
   } host_state_t;
endpackage

// file: rtl/spi_link_if.sv
// Pin-level link between the controller and the memory end
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
   // Select and clock, made by the controller
   logic cs_n;
   logic sck;
   // Line zero: drives from each end, resolved level
   logic l0_host_o;
   logic l0_host_oe;
   logic l0_dev_o;
   logic l0_dev_oe;
   logic dual_line_zero;
   // Line one: drives from each end, resolved level
   logic l1_host_o;
   logic l1_host_oe;
   logic l1_dev_o;
   logic l1_dev_oe;
   logic dual_line_one;
   // Undriven lines float high, as with a weak pull-up
   assign dual_line_zero = l0_host_oe ? l0_host_o :
                           (l0_dev_oe ? l0_dev_o : 1'b1);
   assign dual_line_one  = l1_host_oe ? l1_host_o :
                           (l1_dev_oe ? l1_dev_o : 1'b1);
   modport device (
      input  cs_n, sck, dual_line_zero, dual_line_one,
      output l0_dev_o, l0_dev_oe, l1_dev_o, l1_dev_oe
   );
   modport host (
      input  dual_line_zero, dual_line_one,
      output cs_n, sck, l0_host_o, l0_host_oe, l1_host_o, l1_host_oe
   );
endinterface
`default_nettype wire

// file: rtl/serial_sram_host.sv
// Controller end of the serial link: makes select, clock and data
`timescale 1ns/1ps
`default_nettype none
`include "link_defs.svh"
module serial_sram_host (
   // Link pins
   spi_link_if.host          link,
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Request from the user
   input  wire logic         req_valid,
   output logic              req_ready,
   input  wire logic [7:0]   req_cmd,
   input  wire logic [15:0]  req_addr,
   input  wire logic [7:0]   req_wdata,
   // Read answer
   output logic              rsp_valid,
   output logic [7:0]        rsp_data,
   // Line mode the controller believes in
   output logic              dual_line_mode
);
   // ==========================================================
   // Line synchronisers
   // ==========================================================
   logic [1:0]             l0_s_q;     // Line zero
   logic [1:0]             l1_s_q;     // Line one
   always_ff @(posedge mclk) begin
      if (rst) begin
         l0_s_q <= 2'h3;
         l1_s_q <= 2'h3;
      end else begin
         l0_s_q <= {l0_s_q[0], link.dual_line_zero};
         l1_s_q <= {l1_s_q[0], link.dual_line_one};
      end
   end

   // ==========================================================
   // Sequencer state
   // ==========================================================
   link_pkg::host_state_t  state_q;    // Sequencer state
   logic [7:0]             div_q;      // Half period counter
   logic [31:0]            tx_q;       // Outgoing bits, high first
   logic [5:0]             left_q;     // Bits left in transaction
   logic [5:0]             rxn_q;      // Bits to receive at the end
   logic [7:0]             rx_q;       // Received bits
   logic [7:0]             cmd_q;      // Command in flight
   logic                   both_q;     // Resync: both lines, one step
   logic                   init_q;     // Resync still owed
   logic                   dual_q;     // Believed line mode
   logic                   cs_n_q;     // Select pin
   logic                   sck_q;      // Clock pin
   logic                   l0_q;       // Line zero drive value
   logic                   l1_q;       // Line one drive value
   logic                   oe0_q;      // Line zero enable
   logic                   oe1_q;      // Line one enable
   logic                   rsp_q;      // Answer strobe
   logic [7:0]             rsp_d_q;    // Answer byte

   // ==========================================================
   // Decoding
   // ==========================================================
   logic                   half_end;   // Half period over
   logic [5:0]             step;       // Bits per clock
   logic                   tx_ph;      // Still sending
   logic                   is_rw;      // Request carries an address
   logic [7:0]             rx_next;    // Receive shifter after a rise

   assign half_end  = (div_q == 8'(`SCK_HALF_CYC - 1));
   assign step      = (dual_q && !both_q) ? 6'h2 : 6'h1;
   assign tx_ph     = (left_q > rxn_q);
   assign is_rw     = (req_cmd == `READ_CMD) || (req_cmd == `WRITE_CMD);
   assign rx_next   = dual_q ? {rx_q[5:0], l1_s_q[1], l0_s_q[1]}
                             : {rx_q[6:0], l1_s_q[1]};
   assign req_ready = (state_q == link_pkg::h_idle) & ~init_q;

   // Half period divider, restarts on each phase change
   always_ff @(posedge mclk) begin
      if (rst || state_q == link_pkg::h_idle || half_end) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // Main sequencer; select stays low for the whole transfer
   always_ff @(posedge mclk) begin
      rsp_q <= 1'b0;
      if (rst) begin
         state_q <= link_pkg::h_idle;
         init_q  <= 1'b1;
         dual_q  <= 1'b0;
         both_q  <= 1'b0;
         tx_q    <= 32'h0000_0000;
         left_q  <= 6'h00;
         rxn_q   <= 6'h00;
         rx_q    <= 8'h00;
         cmd_q   <= 8'h00;
         cs_n_q  <= 1'b1;
         sck_q   <= 1'b0;
         {l0_q, l1_q, oe0_q, oe1_q} <= 4'h0;
         rsp_d_q <= 8'h00;
      end else begin
         unique case (state_q)
            link_pkg::h_idle: begin
               if (init_q) begin
                  // Exit code on both lines reads as exit in either
                  // mode, so the memory ends up single line
                  cmd_q   <= `EXIT_DUAL_CMD;
                  tx_q    <= {`EXIT_DUAL_CMD, 24'h00_0000};
                  left_q  <= `CMD_BITS;
                  rxn_q   <= 6'h00;
                  both_q  <= 1'b1;
                  cs_n_q  <= 1'b0;
                  state_q <= link_pkg::h_setup;
               end else if (req_valid) begin
                  cmd_q   <= req_cmd;
                  tx_q    <= {req_cmd, req_addr, req_wdata};
                  left_q  <= is_rw ? `RW_BITS : `CMD_BITS;
                  rxn_q   <= (req_cmd == `READ_CMD) ? `RX_BITS : 6'h00;
                  both_q  <= 1'b0;
                  cs_n_q  <= 1'b0;
                  state_q <= link_pkg::h_setup;
               end
            end
            link_pkg::h_setup, link_pkg::h_high: begin
               if (half_end) begin
                  sck_q <= 1'b0;
                  if (state_q == link_pkg::h_high && left_q == 6'h00) begin
                     {oe0_q, oe1_q} <= 2'h0;
                     state_q <= link_pkg::h_gap;
                  end else begin
                     // New bits go out while the clock is low
                     oe0_q <= tx_ph;
                     oe1_q <= tx_ph & (dual_q | both_q);
                     l0_q  <= (dual_q && !both_q) ? tx_q[30] : tx_q[31];
                     l1_q  <= tx_q[31];
                     tx_q  <= (dual_q && !both_q) ? {tx_q[29:0], 2'h0}
                                                  : {tx_q[30:0], 1'h0};
                     state_q <= link_pkg::h_low;
                  end
               end
            end
            link_pkg::h_low: begin
               if (half_end) begin
                  // Rising edge: the memory takes our bits, we take its
                  sck_q  <= 1'b1;
                  left_q <= left_q - step;
                  if (!tx_ph) begin
                     rx_q <= rx_next;
                  end
                  state_q <= link_pkg::h_high;
               end
            end
            link_pkg::h_gap: begin
               cs_n_q <= 1'b1;
               if (half_end) begin
                  // Mode follows the command once it is complete
                  if (cmd_q == `ENTER_DUAL_CMD) begin
                     dual_q <= 1'b1;
                  end else if (cmd_q == `EXIT_DUAL_CMD) begin
                     dual_q <= 1'b0;
                  end
                  rsp_q   <= (rxn_q != 6'h00);
                  rsp_d_q <= rx_q;
                  init_q  <= 1'b0;
                  state_q <= link_pkg::h_idle;
               end
            end
            default: begin
               state_q <= link_pkg::h_idle;
            end
         endcase
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign link.cs_n       = cs_n_q;
   assign link.sck        = sck_q;
   assign link.l0_host_o  = l0_q;
   assign link.l0_host_oe = oe0_q;
   assign link.l1_host_o  = l1_q;
   assign link.l1_host_oe = oe1_q;
   assign rsp_valid       = rsp_q;
   assign rsp_data        = rsp_d_q;
   assign dual_line_mode  = dual_q;
endmodule
`default_nettype wire

// file: dv/serial_sram_link_asserts.sv
// Checker of the link pins between the two ends
`timescale 1ns/1ps
`default_nettype none
module serial_sram_link_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Select and clock
   input wire logic cs_n,
   input wire logic sck,
   // Line drives from both ends
   input wire logic l0_host_o,
   input wire logic l0_host_oe,
   input wire logic l0_dev_o,
   input wire logic l0_dev_oe,
   input wire logic l1_host_o,
   input wire logic l1_host_oe,
   input wire logic l1_dev_o,
   input wire logic l1_dev_oe
);
   // =========================================
   // One domain: clock and reset given once
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Clock stays low outside a frame
   sck_idle_a : assert property (cs_n |-> !sck)
      else $error("serial clock high while deselected");
   // Select leads the first clock edge
   sel_lead_a : assert property ($fell(cs_n) |-> !sck [*8])
      else $error("clock rose too soon after select");
   // Memory end lets go of both lines once deselected
   dev_release_a : assert property (cs_n [*4] |-> !(l0_dev_oe || l1_dev_oe))
      else $error("memory end drives while deselected");
   // Memory end output moves only in the low phase
   dev_change_a : assert property (
      $changed({l0_dev_o & l0_dev_oe, l1_dev_o & l1_dev_oe})
      |-> !sck && !$past(sck))
      else $error("memory output changed near a rising clock");
   // Controller data holds while the memory samples it
   host_hold_a : assert property (
      sck |-> $stable({l0_host_o & l0_host_oe, l1_host_o & l1_host_oe}))
      else $error("controller data moved while clock high");
   // Shared pins never driven from both ends
   no_clash_a : assert property (
      !(l0_host_oe && l0_dev_oe) && !(l1_host_oe && l1_dev_oe))
      else $error("both ends drive one line");
   // Controller drives line one only as part of a pair
   host_pair_a : assert property (l1_host_oe |-> l0_host_oe)
      else $error("controller drives line one alone");
   // Memory end drives line zero only as part of a pair
   dev_pair_a : assert property (l0_dev_oe |-> l1_dev_oe)
      else $error("memory end drives line zero alone");
endmodule
`default_nettype wire

// file: dv/serial_sram_dual_io_link_tb.sv
// Testbench: controller and memory end joined over the link
`timescale 1ns/1ps
`default_nettype none
`include "link_defs.svh"
module serial_sram_dual_io_link_tb;
   // =========================================
   // Stimulus and observed signals
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        host_rst = 1'b0;    // Controller-only reset
   logic        req_valid = 1'b0;
   logic [7:0]  req_cmd = 8'h00;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0]  req_wdata = 8'h00;
   logic [7:0]  rd_data = 8'h00;
   logic        req_ready, rsp_valid, wr_valid, rd_req;
   logic        dev_dual, host_dual;
   logic [15:0] wr_addr, rd_addr, seen_wa, seen_ra;
   logic [7:0]  wr_data, rsp_data, seen_wd;
   logic [7:0]  cmds [6] = '{8'h3B, 8'h05, 8'hFF, 8'h01, 8'h3B, 8'h3B};
   logic [15:0] a;
   logic [7:0]  d;
   logic        mode;
   logic        ra_taken = 1'b0;  // First fetch of a frame seen
   int          bad_count = 0;
   int          n_tests = 0;
   int          seed;
   // Clock of 4 ns
   always #2 mclk = ~mclk;
   // =========================================
   // Link, both ends and the checker
   spi_link_if spi_link_if_i ();
   serial_sram_dev serial_sram_dev_i (.link(spi_link_if_i), .mclk(mclk),
      .rst(rst), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
      .dual_line_mode(dev_dual));
   serial_sram_host serial_sram_host_i (.link(spi_link_if_i), .mclk(mclk),
      .rst(rst || host_rst), .req_valid(req_valid), .req_ready(req_ready),
      .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dual_line_mode(host_dual));
   serial_sram_link_asserts serial_sram_link_asserts_i (.mclk(mclk),
      .rst(rst), .cs_n(spi_link_if_i.cs_n), .sck(spi_link_if_i.sck),
      .l0_host_o(spi_link_if_i.l0_host_o),
      .l0_host_oe(spi_link_if_i.l0_host_oe),
      .l0_dev_o(spi_link_if_i.l0_dev_o), .l0_dev_oe(spi_link_if_i.l0_dev_oe),
      .l1_host_o(spi_link_if_i.l1_host_o),
      .l1_host_oe(spi_link_if_i.l1_host_oe),
      .l1_dev_o(spi_link_if_i.l1_dev_o), .l1_dev_oe(spi_link_if_i.l1_dev_oe));
   // Latch what the memory end hands its storage side
   always @(posedge mclk) begin
      if (wr_valid) begin
         seen_wa <= wr_addr;
         seen_wd <= wr_data;
      end
      // Later fetches prefetch the next byte, so keep the first only
      if (rd_req && !ra_taken) begin
         seen_ra <= rd_addr;
      end
      ra_taken <= spi_link_if_i.cs_n ? 1'b0 : (ra_taken | rd_req);
   end
   // =========================================
   // Line mode expected after a bare command
   function automatic logic next_mode(input logic cur, input logic [7:0] c);
      if (c == `ENTER_DUAL_CMD) begin
         return 1'b1;
      end
      return (c == `EXIT_DUAL_CMD) ? 1'b0 : cur;
   endfunction
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Bounded wait for the controller to be idle
   task automatic wait_ready();
      int k;
      k = 0;
      while (req_ready !== 1'b1 && k < 5000) begin
         @(negedge mclk);
         k++;
      end
      if (k >= 5000) begin
         bad_count++;
         $display("Error at %0t: controller never ready", $time);
      end
   endtask
   // One request, held until taken, then wait for completion
   task automatic send(input logic [7:0] c, input logic [15:0] ad,
                       input logic [7:0] wd);
      wait_ready();
      req_valid = 1'b1;
      req_cmd = c;
      req_addr = ad;
      req_wdata = wd;
      @(negedge mclk);
      req_valid = 1'b0;
      wait_ready();
   endtask
   // Verdict and end of run
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Watchdog: about 15k cycles expected, limit 50k cycles
   initial begin
      #200000;
      bad_count++;
      summarize();
   end
   // =========================================
   // Main sequence
   initial begin
      seed = $urandom(2811);
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      mode = 1'b0;
      wait_ready();
      check(16'(dev_dual), 16'h0000);
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 16'hFFFF : 16'($urandom);
         d = (i == 1) ? 8'h00 : 8'($urandom);
         send(`WRITE_CMD, a, d);
         check(seen_wa, a);
         check(16'(seen_wd), 16'(d));
         check(16'(rsp_valid), 16'h0000);
         rd_data = 8'($urandom);
         send(`READ_CMD, ~a, 8'h00);
         check(seen_ra, ~a);
         check(16'(rsp_valid), 16'h0001);
         check(16'(rsp_data), 16'(rd_data));
         send(cmds[i], 16'h0000, 8'h00);
         mode = next_mode(mode, cmds[i]);
         check(16'(dev_dual), 16'(mode));
         check(16'(host_dual), 16'(mode));
         $display("Test %0d done", i);
      end
      // Controller alone restarts while the memory is in dual mode
      host_rst = 1'b1;
      repeat (2) @(negedge mclk);
      host_rst = 1'b0;
      @(negedge mclk);
      wait_ready();
      check(16'(dev_dual), 16'h0000);
      check(16'(host_dual), 16'h0000);
      $display("Test resync done");
      summarize();
   end
endmodule
`default_nettype wire
